//--- hw/cae_exec.sv
// execution datapath top: apb command port, sequencing and status flags
`include "cae_defs.svh"
module cae_exec (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [15:0] result_q,
	output logic [7:0] sreg_q,
	output logic [15:0] pc_q,
	output logic busy_q,
	output logic done_q
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	cae_pkg::cae_state_t state_q;
	cae_pkg::cae_state_t state_d;
	cae_pkg::cae_operand_t opnd_q;
	cae_pkg::cae_op_t op_q;
	cae_pkg::cae_result_t alu_res;
	logic [15:0] z_q;
	logic [1:0] cyc_q;
	logic [1:0] need;
	logic wr_en;
	logic rd_en;
	logic start;
	logic unmapped;

	function automatic logic [1:0] op_cycles(input cae_pkg::cae_op_t op);
		if (op == cae_pkg::CAE_OP_WADD || op == cae_pkg::CAE_OP_WSUB) begin
			return 2'(`CAE_CYC_DOUBLE);
		end else if (op >= cae_pkg::CAE_OP_MULU) begin
			return 2'(`CAE_CYC_DOUBLE);
		end
		return 2'(`CAE_CYC_SINGLE);
	endfunction

	function automatic logic is_mapped(input logic [11:0] a);
		if (a == `CAE_OFS_OPERAND) begin
			return 1'b1;
		end else if (a == `CAE_OFS_COMMAND) begin
			return 1'b1;
		end else if (a == `CAE_OFS_RESULT) begin
			return 1'b1;
		end else if (a == `CAE_OFS_STATUS) begin
			return 1'b1;
		end else if (a == `CAE_OFS_PC) begin
			return 1'b1;
		end else if (a == `CAE_OFS_Z) begin
			return 1'b1;
		end
		return 1'b0;
	endfunction

	cae_alu u_alu (
		.op(op_q),
		.opnd(opnd_q),
		.sreg(sreg_q),
		.res(alu_res)
	);

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	assign unmapped = ~is_mapped(paddr);
	assign wr_en = clk_en & psel & penable & pwrite & ~unmapped;
	// read data is captured in the setup cycle so it already stands when pready is sampled
	assign rd_en = clk_en & psel & ~penable & ~pwrite;
	// a command written while busy is dropped; software polls busy first
	assign start = wr_en & (paddr == `CAE_OFS_COMMAND) & (state_q == cae_pkg::CAE_ST_IDLE);
	assign need = op_cycles(op_q);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (clk_en) begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & unmapped;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_en) begin
			if (paddr == `CAE_OFS_OPERAND) begin
				prdata <= {8'h00, opnd_q};
			end else if (paddr == `CAE_OFS_COMMAND) begin
				prdata <= {27'h000_0000, op_q};
			end else if (paddr == `CAE_OFS_RESULT) begin
				prdata <= {16'h0000, result_q};
			end else if (paddr == `CAE_OFS_STATUS) begin
				prdata <= {22'h00_0000, done_q, busy_q, sreg_q};
			end else if (paddr == `CAE_OFS_PC) begin
				prdata <= {16'h0000, pc_q};
			end else if (paddr == `CAE_OFS_Z) begin
				prdata <= {16'h0000, z_q};
			end else begin
				prdata <= 32'h0000_0000;
			end
		end
	end

	// ----------------------------------------
	// software-written registers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			opnd_q <= '0;
			z_q <= 16'h0000;
		end else if (wr_en) begin
			if (paddr == `CAE_OFS_OPERAND && state_q == cae_pkg::CAE_ST_IDLE) begin
				opnd_q <= pwdata[23:0];
			end else if (paddr == `CAE_OFS_Z) begin
				z_q <= pwdata[15:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_q <= cae_pkg::CAE_OP_ADD;
		end else if (start) begin
			op_q <= cae_pkg::cae_op_t'(pwdata[4:0]);
		end
	end

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_comb begin
		state_d = state_q;
		case (state_q)
			cae_pkg::CAE_ST_IDLE: begin
				if (start) begin
					state_d = cae_pkg::CAE_ST_EXEC;
				end
			end
			cae_pkg::CAE_ST_EXEC: begin
				if (cyc_q + 2'd1 >= need) begin
					state_d = cae_pkg::CAE_ST_DONE;
				end
			end
			default: begin
				state_d = cae_pkg::CAE_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= cae_pkg::CAE_ST_IDLE;
			cyc_q <= 2'd0;
		end else if (clk_en) begin
			state_q <= state_d;
			if (state_q == cae_pkg::CAE_ST_EXEC) begin
				cyc_q <= cyc_q + 2'd1;
			end else begin
				cyc_q <= 2'd0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else if (clk_en) begin
			busy_q <= (state_d == cae_pkg::CAE_ST_EXEC);
			done_q <= (state_d == cae_pkg::CAE_ST_DONE);
		end
	end

	// ----------------------------------------
	// writeback: result, flags, program counter
	// ----------------------------------------
	// commit on the last execute clock so the visible latency equals the op's clock count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result_q <= 16'h0000;
			sreg_q <= `CAE_SREG_RST;
			pc_q <= 16'h0000;
		end else if (clk_en && state_q == cae_pkg::CAE_ST_EXEC && state_d == cae_pkg::CAE_ST_DONE) begin
			if (op_q == cae_pkg::CAE_OP_PJMP) begin
				pc_q <= z_q;
			end else if (op_q == cae_pkg::CAE_OP_TEST) begin
				result_q <= {8'h00, opnd_q.rd};
			end else begin
				result_q <= alu_res.value;
			end
			sreg_q <= alu_res.flags;
		end
	end
endmodule

//--- common/cae_defs.svh
// constants for the arithmetic and logic execution datapath
`ifndef CAE_DEFS_SVH
`define CAE_DEFS_SVH
// ----------------------------------------
// register map
// ----------------------------------------
`define CAE_OFS_OPERAND 12'h000
`define CAE_OFS_COMMAND 12'h004
`define CAE_OFS_RESULT 12'h008
`define CAE_OFS_STATUS 12'h00C
`define CAE_OFS_PC 12'h010
`define CAE_OFS_Z 12'h014
// ----------------------------------------
// status bit positions
// ----------------------------------------
`define CAE_SREG_C 0
`define CAE_SREG_Z 1
`define CAE_SREG_N 2
`define CAE_SREG_V 3
`define CAE_SREG_S 4
`define CAE_SREG_H 5
`define CAE_SREG_RST 8'h00
`define CAE_BYTE_ALL 8'hFF
// ----------------------------------------
// timing, in clocks
// ----------------------------------------
`define CAE_CYC_SINGLE 1
`define CAE_CYC_DOUBLE 2
`endif

//--- common/cae_pkg.sv
// types for the arithmetic and logic execution datapath
package cae_pkg;
	typedef enum logic [4:0] {
		CAE_OP_ADD = 5'h00,
		CAE_OP_ADC = 5'h01,
		CAE_OP_WADD = 5'h02,
		CAE_OP_SUB = 5'h03,
		CAE_OP_SUBTRACT_IMMEDIATE = 5'h04,
		CAE_OP_SBC = 5'h05,
		CAE_OP_SUBTRACT_CARRY_IMMEDIATE = 5'h06,
		CAE_OP_WSUB = 5'h07,
		CAE_OP_AND = 5'h08,
		CAE_OP_AND_IMMEDIATE = 5'h09,
		CAE_OP_OR = 5'h0A,
		CAE_OP_ORI = 5'h0B,
		CAE_OP_XOR = 5'h0C,
		CAE_OP_SETB = 5'h0D,
		CAE_OP_CLRB = 5'h0E,
		CAE_OP_TEST = 5'h0F,
		CAE_OP_MULU = 5'h10,
		CAE_OP_MULTIPLY_SIGNED = 5'h11,
		CAE_OP_MULTIPLY_SIGNED_UNSIGNED = 5'h12,
		CAE_OP_FMULU = 5'h13,
		CAE_OP_FRACTIONAL_MULTIPLY_SIGNED = 5'h14,
		CAE_OP_FRACTIONAL_MULTIPLY_MIXED = 5'h15,
		CAE_OP_PJMP = 5'h16
	} cae_op_t;
	typedef enum logic [1:0] {
		CAE_ST_IDLE = 2'b00,
		CAE_ST_EXEC = 2'b01,
		CAE_ST_DONE = 2'b11
	} cae_state_t;
	typedef struct packed {
		logic [7:0] rd;
		logic [7:0] rr;
		logic [7:0] imm;
	} cae_operand_t;
	typedef struct packed {
		logic [15:0] value;
		logic [7:0] flags;
	} cae_result_t;
endpackage

//--- hw/cae_alu.sv
// combinational arithmetic, logic and multiply unit
`include "cae_defs.svh"
module cae_alu (
	input wire cae_pkg::cae_op_t op,
	input wire cae_pkg::cae_operand_t opnd,
	input wire logic [7:0] sreg,
	output cae_pkg::cae_result_t res
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [7:0] logic_flags(input logic [7:0] s, input logic [7:0] r);
		logic [7:0] f;
		f = s;
		f[`CAE_SREG_Z] = (r == 8'h00);
		f[`CAE_SREG_N] = r[7];
		f[`CAE_SREG_V] = 1'b0;
		f[`CAE_SREG_S] = r[7];
		return f;
	endfunction

	function automatic logic [8:0] add8(input logic [7:0] a, input logic [7:0] b, input logic ci);
		return {1'b0, a} + {1'b0, b} + {8'h00, ci};
	endfunction

	logic [7:0] a;
	logic [7:0] b;
	logic [7:0] r8;
	logic [8:0] s9;
	logic [15:0] w;
	logic [15:0] wr;
	logic [15:0] prod;
	logic [7:0] f;
	logic cin;
	logic sub;

	always_comb begin
		a = opnd.rd;
		b = opnd.rr;
		r8 = 8'h00;
		s9 = 9'h000;
		w = {opnd.rd, opnd.rr};
		wr = 16'h0000;
		prod = 16'h0000;
		f = sreg;
		cin = 1'b0;
		sub = 1'b0;
		case (op)
			cae_pkg::CAE_OP_ADD, cae_pkg::CAE_OP_ADC: begin
				cin = (op == cae_pkg::CAE_OP_ADC) & sreg[`CAE_SREG_C];
				s9 = add8(a, b, cin);
				r8 = s9[7:0];
				f[`CAE_SREG_C] = s9[8];
				f[`CAE_SREG_H] = (a[3] & b[3]) | (b[3] & ~r8[3]) | (~r8[3] & a[3]);
				f[`CAE_SREG_V] = (a[7] & b[7] & ~r8[7]) | (~a[7] & ~b[7] & r8[7]);
				sub = 1'b0;
			end
			cae_pkg::CAE_OP_SUB, cae_pkg::CAE_OP_SUBTRACT_IMMEDIATE, cae_pkg::CAE_OP_SBC, cae_pkg::CAE_OP_SUBTRACT_CARRY_IMMEDIATE: begin
				if (op == cae_pkg::CAE_OP_SUBTRACT_IMMEDIATE || op == cae_pkg::CAE_OP_SUBTRACT_CARRY_IMMEDIATE) begin
					b = opnd.imm;
				end
				cin = (op == cae_pkg::CAE_OP_SBC || op == cae_pkg::CAE_OP_SUBTRACT_CARRY_IMMEDIATE) & sreg[`CAE_SREG_C];
				s9 = {1'b0, a} - {1'b0, b} - {8'h00, cin};
				r8 = s9[7:0];
				f[`CAE_SREG_C] = s9[8];
				f[`CAE_SREG_H] = (~a[3] & b[3]) | (b[3] & r8[3]) | (r8[3] & ~a[3]);
				f[`CAE_SREG_V] = (a[7] & ~b[7] & ~r8[7]) | (~a[7] & b[7] & r8[7]);
				sub = 1'b1;
			end
			cae_pkg::CAE_OP_WADD, cae_pkg::CAE_OP_WSUB: begin
				if (op == cae_pkg::CAE_OP_WADD) begin
					wr = w + {8'h00, opnd.imm};
					f[`CAE_SREG_C] = ~wr[15] & w[15];
					f[`CAE_SREG_V] = ~w[15] & wr[15];
				end else begin
					wr = w - {8'h00, opnd.imm};
					f[`CAE_SREG_C] = wr[15] & ~w[15];
					f[`CAE_SREG_V] = w[15] & ~wr[15];
				end
				f[`CAE_SREG_Z] = (wr == 16'h0000);
				f[`CAE_SREG_N] = wr[15];
				f[`CAE_SREG_S] = wr[15] ^ f[`CAE_SREG_V];
			end
			cae_pkg::CAE_OP_AND, cae_pkg::CAE_OP_AND_IMMEDIATE, cae_pkg::CAE_OP_TEST: begin
				if (op == cae_pkg::CAE_OP_AND_IMMEDIATE) begin
					b = opnd.imm;
				end else if (op == cae_pkg::CAE_OP_TEST) begin
					b = a;
				end
				r8 = a & b;
				f = logic_flags(sreg, r8);
			end
			cae_pkg::CAE_OP_OR, cae_pkg::CAE_OP_ORI, cae_pkg::CAE_OP_SETB: begin
				if (op != cae_pkg::CAE_OP_OR) begin
					b = opnd.imm;
				end
				r8 = a | b;
				f = logic_flags(sreg, r8);
			end
			cae_pkg::CAE_OP_XOR: begin
				r8 = a ^ b;
				f = logic_flags(sreg, r8);
			end
			cae_pkg::CAE_OP_CLRB: begin
				r8 = a & (`CAE_BYTE_ALL - opnd.imm);
				f = logic_flags(sreg, r8);
			end
			cae_pkg::CAE_OP_MULU, cae_pkg::CAE_OP_FMULU: begin
				prod = {8'h00, a} * {8'h00, b};
			end
			cae_pkg::CAE_OP_MULTIPLY_SIGNED, cae_pkg::CAE_OP_FRACTIONAL_MULTIPLY_SIGNED: begin
				prod = 16'($signed({{8{a[7]}}, a}) * $signed({{8{b[7]}}, b}));
			end
			cae_pkg::CAE_OP_MULTIPLY_SIGNED_UNSIGNED, cae_pkg::CAE_OP_FRACTIONAL_MULTIPLY_MIXED: begin
				prod = 16'($signed({{8{a[7]}}, a}) * $signed({8'h00, b}));
			end
			default: begin
				f = sreg;
			end
		endcase
		if (op >= cae_pkg::CAE_OP_MULU && op <= cae_pkg::CAE_OP_FRACTIONAL_MULTIPLY_MIXED) begin
			f[`CAE_SREG_C] = prod[15];
			if (op >= cae_pkg::CAE_OP_FMULU) begin
				prod = {prod[14:0], 1'b0};
			end
			f[`CAE_SREG_Z] = (prod == 16'h0000);
		end
		if (op == cae_pkg::CAE_OP_ADD || op == cae_pkg::CAE_OP_ADC || sub) begin
			f[`CAE_SREG_Z] = (r8 == 8'h00);
			f[`CAE_SREG_N] = r8[7];
			f[`CAE_SREG_S] = r8[7] ^ f[`CAE_SREG_V];
		end
		if (op == cae_pkg::CAE_OP_WADD || op == cae_pkg::CAE_OP_WSUB) begin
			res.value = wr;
		end else if (op >= cae_pkg::CAE_OP_MULU && op <= cae_pkg::CAE_OP_FRACTIONAL_MULTIPLY_MIXED) begin
			res.value = prod;
		end else begin
			res.value = {8'h00, r8};
		end
		res.flags = f;
	end
endmodule

//--- sim/cae_exec_asserts.sv
// checker: timing and flag relations of the execution datapath
module cae_exec_asserts (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [15:0] result_q,
	input wire logic [7:0] sreg_q,
	input wire logic [15:0] pc_q,
	input wire logic busy_q,
	input wire logic done_q
);
	// ----------------------------------------
	// last command, pointer and operands
	// ----------------------------------------
	logic [4:0] op_q;
	logic [15:0] z_q, ab_q;
	logic wr, cmd;
	assign wr = psel && penable && pready && pwrite && clk_en;
	assign cmd = wr && paddr == 12'h004 && !busy_q && !done_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_q <= 5'h00;
			z_q <= 16'h0000;
			ab_q <= 16'h0000;
		end else begin
			if (cmd)
				op_q <= pwdata[4:0];
			if (wr && paddr == 12'h014)
				z_q <= pwdata[15:0];
			// operand writes while busy are dropped by the unit, so ignore them here too
			if (wr && paddr == 12'h000 && !busy_q && !done_q)
				ab_q <= pwdata[23:8];
		end
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_one;
		##1 busy_q ##1 (done_q && !busy_q);
	endsequence
	sequence s_two;
		##1 busy_q [*2] ##1 (done_q && !busy_q);
	endsequence
	property p_one;
		cmd && pwdata[4:0] inside {5'h00, 5'h01, [5'h03:5'h06], [5'h08:5'h0F]} |-> s_one;
	endproperty
	property p_two;
		cmd && pwdata[4:0] inside {5'h02, 5'h07, [5'h10:5'h16]} |-> s_two;
	endproperty
	property p_add;
		done_q && op_q <= 5'h01 |-> result_q[7:0] == ab_q[15:8] + ab_q[7:0] + (op_q[0] & $past(sreg_q[0]))
			&& sreg_q[1] == (result_q[7:0] == 8'h00);
	endproperty
	property p_word;
		done_q && op_q inside {5'h02, 5'h07} |-> sreg_q[1] == (result_q == 16'h0000)
			&& sreg_q[2] == result_q[15] && sreg_q[5] == $past(sreg_q[5]);
	endproperty
	property p_logic;
		done_q && op_q inside {[5'h08:5'h0F]} |-> sreg_q[2] == result_q[7] && !sreg_q[3]
			&& sreg_q[1] == (result_q[7:0] == 8'h00) && (sreg_q & 8'h21) == ($past(sreg_q) & 8'h21);
	endproperty
	property p_mulkeep;
		done_q && op_q inside {[5'h10:5'h15]} |-> sreg_q[1] == (result_q == 16'h0000)
			&& (sreg_q & 8'hFC) == ($past(sreg_q) & 8'hFC);
	endproperty
	property p_mulc;
		done_q && op_q inside {[5'h10:5'h12]} |-> sreg_q[0] == result_q[15];
	endproperty
	property p_jump;
		done_q && op_q == 5'h16 |-> pc_q == z_q && $stable(sreg_q);
	endproperty
	a_one: assert property (p_one)
		else $error("one-clock op timing");
	a_two: assert property (p_two)
		else $error("two-clock op timing");
	a_add: assert property (p_add)
		else $error("add result or zero flag");
	a_word: assert property (p_word)
		else $error("word op flags");
	a_logic: assert property (p_logic)
		else $error("logic op flags");
	a_mulkeep: assert property (p_mulkeep)
		else $error("multiply flags");
	a_mulc: assert property (p_mulc)
		else $error("multiply carry");
	a_jump: assert property (p_jump)
		else $error("pointer jump");
endmodule
bind cae_exec cae_exec_asserts cae_exec_asserts_inst (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .result_q(result_q), .sreg_q(sreg_q), .pc_q(pc_q),
	.busy_q(busy_q), .done_q(done_q));

//--- sim/cae_dec_model.sv
// decoder and register-file side model, issuing operations over apb
module cae_dec_model (
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	timeunit 1ns;
	timeprecision 1ns;
	logic hung;
	initial begin
		hung = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
	end
	// ----------------------------------------
	// one transfer, held until pready
	// ----------------------------------------
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		hung = hung | (n >= 16);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// operands, command, then poll until idle; a busy unit drops new commands
	task automatic run_op(input logic [4:0] op, input cae_pkg::cae_operand_t o, output logic [15:0] v,
		output logic [7:0] s);
		logic [31:0] r;
		logic e;
		int n;
		n = 0;
		xfer(1'b1, 12'h000, {8'h00, o}, r, e);
		xfer(1'b1, 12'h004, {27'h000_0000, op}, r, e);
		do begin
			xfer(1'b0, 12'h00C, 32'h0000_0000, r, e);
			n++;
		end while (r[8] !== 1'b0 && n < 16);
		hung = hung | (n >= 16);
		s = r[7:0];
		xfer(1'b0, 12'h008, 32'h0000_0000, r, e);
		v = r[15:0];
	endtask
endmodule

//--- sim/testbench.sv
// self-checking bench for the execution datapath
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, busy_q, done_q;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [15:0] result_q, pc_q;
	logic [7:0] sreg_q;
	int err_total, checked;
	cae_exec cae_exec_inst (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.result_q(result_q), .sreg_q(sreg_q), .pc_q(pc_q), .busy_q(busy_q), .done_q(done_q));
	cae_dec_model cae_dec_model_inst (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic final_report;
		$display("comparisons %0d, mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string m);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
		end
		if (cae_dec_model_inst.hung) begin
			err_total++;
			final_report();
		end
	endtask
	// sign flag left out for byte add and subtract, where its update is not pinned down
	task automatic chk(input logic [4:0] op, input cae_pkg::cae_operand_t o, input logic [15:0] v,
		input logic [7:0] s);
		logic [15:0] gv;
		logic [7:0] gs, m;
		cae_dec_model_inst.run_op(op, o, gv, gs);
		m = (op inside {5'h00, 5'h01, [5'h03:5'h06]}) ? 8'hEF : 8'hFF;
		if (!(op inside {5'h02, 5'h07, [5'h10:5'h15]}))
			gv[15:8] = 8'h00;
		cmp(gv, v, "result");
		cmp({8'h00, gs & m}, {8'h00, s & m}, "flags");
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_add;
		chk(5'h00, 24'h0F_0100, 16'h0010, 8'h20);
		chk(5'h00, 24'h80_8000, 16'h0000, 8'h0B);
		chk(5'h01, 24'h01_0100, 16'h0003, 8'h00);
	endtask
	task automatic t_sub;
		chk(5'h03, 24'h00_0100, 16'h00FF, 8'h25);
		chk(5'h05, 24'h10_0F00, 16'h0000, 8'h22);
		chk(5'h04, 24'h05_0005, 16'h0000, 8'h02);
		chk(5'h06, 24'h80_0001, 16'h007F, 8'h28);
	endtask
	task automatic t_word;
		chk(5'h02, 24'h12_FF01, 16'h1300, 8'h20);
		chk(5'h07, 24'h00_0001, 16'hFFFF, 8'h35);
	endtask
	task automatic t_logic;
		chk(5'h08, 24'hF0_0F00, 16'h0000, 8'h23);
		chk(5'h09, 24'hFF_0080, 16'h0080, 8'h35);
		chk(5'h0A, 24'h00_0000, 16'h0000, 8'h23);
		chk(5'h0B, 24'h01_0080, 16'h0081, 8'h35);
		chk(5'h0C, 24'hAA_AA00, 16'h0000, 8'h23);
		chk(5'h0D, 24'h00_0040, 16'h0040, 8'h21);
		chk(5'h0E, 24'hFF_000F, 16'h00F0, 8'h35);
		chk(5'h0F, 24'h00_0000, 16'h0000, 8'h23);
	endtask
	task automatic t_mul;
		chk(5'h10, 24'hFF_FF00, 16'hFE01, 8'h21);
		chk(5'h11, 24'hFF_0100, 16'hFFFF, 8'h21);
		chk(5'h12, 24'h80_0200, 16'hFF00, 8'h21);
		chk(5'h13, 24'h80_8000, 16'h8000, 8'h20);
		chk(5'h14, 24'h00_0500, 16'h0000, 8'h22);
		chk(5'h15, 24'hC0_8000, 16'hC000, 8'h21);
	endtask
	task automatic t_jump;
		logic [31:0] r;
		logic e;
		logic [15:0] v;
		logic [7:0] s;
		cae_dec_model_inst.xfer(1'b1, 12'h014, 32'h0000_1234, r, e);
		cae_dec_model_inst.run_op(5'h16, 24'h00_0000, v, s);
		cmp({8'h00, s}, 16'h0021, "flags");
		cae_dec_model_inst.xfer(1'b0, 12'h010, 32'h0000_0000, r, e);
		cmp(r[15:0], 16'h1234, "pc");
	endtask
	// clock enable low must freeze the result and flag outputs
	task automatic t_freeze;
		logic [15:0] v;
		logic [7:0] s;
		v = result_q;
		s = sreg_q;
		@(posedge pclk);
		clk_en <= 1'b0;
		repeat (4) @(posedge pclk);
		cmp(result_q, v, "frozen result");
		cmp({8'h00, sreg_q}, {8'h00, s}, "frozen flags");
		clk_en <= 1'b1;
	endtask
	task automatic t_bus;
		logic [31:0] r;
		logic e;
		cae_dec_model_inst.xfer(1'b0, 12'h018, 32'h0000_0000, r, e);
		cmp({r[15:1], e}, 16'h0001, "unmapped read");
	endtask
	initial begin
		err_total = 0;
		checked = 0;
		presetn = 1'b0;
		clk_en = 1'b1;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_add();
		t_sub();
		t_word();
		t_logic();
		t_mul();
		t_jump();
		t_freeze();
		t_bus();
		final_report();
	end
endmodule
